// file: dbs_ctrl_end.sv
`timescale 1ns/100ps
module dbs_ctrl_end
  import dbs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic dll_on,
  input wire logic rd_req,
  input wire logic wr_req,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [BEATS_W-1:0] wr_data,
  input wire logic [MASK_W-1:0] wr_mask_n,
  output logic cmd_ready,
  output logic [BEATS_W-1:0] rd_data,
  output logic rd_valid,
  dbs_link_if.ctrl lk
);
  localparam int REST_W = BEATS_W - DATA_W;
  localparam int MREST_W = MASK_W - NBYTES;

  logic k_r;
  logic [1:0] cnt_r;
  logic rd_n_r;
  logic wr_n_r;
  logic dll_r;
  logic [ADDR_W-1:0] addr_r;
  logic [BEATS_W-1:0] hold_d_r;
  logic [MASK_W-1:0] hold_m_r;
  logic wpend_r;
  logic [REST_W-1:0] wsh_r;
  logic [MREST_W-1:0] msh_r;
  logic [1:0] wleft_r;
  logic [DATA_W-1:0] wd_r;
  logic [NBYTES-1:0] wm_r;
  logic [DATA_W-1:0] wd_o_r;
  logic [NBYTES-1:0] wm_o_r;
  logic [DATA_W:0] ret_s;
  logic [REST_W-1:0] rbuf_r;
  logic [1:0] rcnt_r;
  logic [BEATS_W-1:0] rd_data_r;
  logic rd_valid_r;

  // Commands change as k falls, half a link cycle before the rise that takes them
  wire slot_free = (cnt_r == 2'd0);
  wire accept = cmd_ready & (rd_req | wr_req);
  wire load_w = k_r & (cnt_r == 2'd2) & wpend_r;
  wire ret_v = ret_s[DATA_W];
  wire [DATA_W-1:0] ret_d = ret_s[DATA_W-1:0];

  // Link clock pair is a divider output, 25 MHz, under the bypass limit
  assign lk.k = k_r;
  assign lk.k_n = ~k_r;
  assign lk.rd_n = rd_n_r;
  assign lk.wr_n = wr_n_r;
  assign lk.dll_enable = dll_r;
  assign lk.addr_bus = addr_r;
  assign lk.write_bus_in = wd_o_r;
  assign lk.byte_mask_n = wm_o_r;
  assign cmd_ready = ce & k_r & slot_free;
  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;

  // Returned beats are synchronous to core_clk by construction; two stages keep alignment
  dbs_sync #(.W(DATA_W + 1)) u_ret_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .en(ce),
    .d({lk.out_valid_flag, lk.read_bus_out}),
    .q(ret_s)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      k_r <= 1'b0;
      cnt_r <= 2'd0;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      dll_r <= 1'b0;
      addr_r <= '0;
      hold_d_r <= '0;
      hold_m_r <= '1;
      wpend_r <= 1'b0;
    end else if (ce) begin
      k_r <= ~k_r;
      dll_r <= dll_on;
      if (k_r) begin
        rd_n_r <= ~(accept & rd_req);
        wr_n_r <= ~(accept & wr_req);
      end
      if (accept) begin
        addr_r <= cmd_addr;
        hold_d_r <= wr_data;
        hold_m_r <= wr_mask_n;
        wpend_r <= wr_req;
        cnt_r <= 2'(CMD_SPACING - 1);
      end else if (!slot_free) begin
        cnt_r <= cnt_r - 2'd1;
      end
    end
  end

  // Beat one goes out a full cycle after the command, then one beat per edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wsh_r <= '0;
      msh_r <= '1;
      wleft_r <= 2'd0;
      wd_r <= '0;
      wm_r <= MASK_NONE;
    end else if (ce) begin
      if (load_w) begin
        wd_r <= hold_d_r[DATA_W-1:0];
        wm_r <= hold_m_r[NBYTES-1:0];
        wsh_r <= hold_d_r[BEATS_W-1:DATA_W];
        msh_r <= hold_m_r[MASK_W-1:NBYTES];
        wleft_r <= 2'd3;
      end else if (wleft_r != 2'd0) begin
        wd_r <= wsh_r[DATA_W-1:0];
        wm_r <= msh_r[NBYTES-1:0];
        wsh_r <= {{DATA_W{1'b0}}, wsh_r[REST_W-1:DATA_W]};
        msh_r <= {MASK_NONE, msh_r[MREST_W-1:NBYTES]};
        wleft_r <= wleft_r - 2'd1;
      end else begin
        wm_r <= MASK_NONE;
      end
    end
  end

  // Data moves on the falling core edge, a quarter link cycle clear of both k edges
  always_ff @(negedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_o_r <= '0;
      wm_o_r <= MASK_NONE;
    end else if (ce) begin
      wd_o_r <= wd_r;
      wm_o_r <= wm_r;
    end
  end

  // Four valid beats in a row make one burst; beat one lands lowest
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rbuf_r <= '0;
      rcnt_r <= 2'd0;
      rd_data_r <= '0;
      rd_valid_r <= 1'b0;
    end else if (ce) begin
      rd_valid_r <= 1'b0;
      if (ret_v) begin
        rbuf_r <= {ret_d, rbuf_r[REST_W-1:DATA_W]};
        rcnt_r <= rcnt_r + 2'd1;
        if (rcnt_r == 2'd3) begin
          rd_data_r <= {ret_d, rbuf_r};
          rd_valid_r <= 1'b1;
        end
      end
    end
  end
endmodule : dbs_ctrl_end

// file: dbs_link_asserts.sv
`timescale 1ns/100ps
module dbs_link_asserts
  import dbs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic k,
  input wire logic k_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic dll_enable,
  input wire logic [DATA_W-1:0] read_bus_out,
  input wire logic echo_out_true,
  input wire logic echo_out_comp,
  input wire logic out_valid_flag
);
  logic [5:0] dll_cnt_r;
  wire logic settled;
  // Lock state is not on the link, so latency is only judged long after the DLL input settles
  assign settled = dll_cnt_r == 6'h3F;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) dll_cnt_r <= 6'h00;
    else if ($changed(dll_enable)) dll_cnt_r <= 6'h00;
    else if (!settled) dll_cnt_r <= dll_cnt_r + 6'h01;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_comp_clk_inv: assert property (k_n == ~k)
    else $error("k_n is not the inverse of k");
  a_echo_pair_inv: assert property (echo_out_comp == ~echo_out_true)
    else $error("echo pair not complementary");
  a_echo_free_run: assert property ($past(rst_n, 2) |-> $changed(echo_out_true))
    else $error("echo clock stopped");
  a_valid_on_echo: assert property (($rose(out_valid_flag) || $fell(out_valid_flag))
    |-> $changed(echo_out_true) && !echo_out_true)
    else $error("valid flag moved off an echo edge");
  a_idle_bus_quiet: assert property (!out_valid_flag |-> read_bus_out == '0)
    else $error("read bus driven outside a read beat");
  a_cmd_on_k_rise: assert property (($fell(rd_n) || $fell(wr_n)) |-> !k ##1 (k
    && $stable(rd_n) && $stable(wr_n)))
    else $error("command not aligned to k rise");
  a_rd_spacing: assert property ($fell(rd_n) |=> !rd_n ##1 rd_n [*2])
    else $error("reads closer than two link cycles");
  a_rd_lat_locked: assert property ($fell(rd_n) && dll_enable && settled
    |-> ##6 out_valid_flag [*4])
    else $error("locked read burst mistimed");
  a_rd_lat_bypass: assert property ($fell(rd_n) && !dll_enable && settled
    |-> ##4 out_valid_flag [*4])
    else $error("bypass read burst mistimed");
  c_rd_locked: cover property ($fell(rd_n) && dll_enable && settled);
  c_rd_bypass: cover property ($fell(rd_n) && !dll_enable && settled);
  c_write: cover property ($fell(wr_n));
endmodule : dbs_link_asserts

// file: dbs_link_if.sv
`timescale 1ns/100ps
interface dbs_link_if
  import dbs_pkg::*;
  ;
  logic k;
  logic k_n;
  logic rd_n;
  logic wr_n;
  logic dll_enable;
  logic [ADDR_W-1:0] addr_bus;
  logic [DATA_W-1:0] write_bus_in;
  logic [NBYTES-1:0] byte_mask_n;
  logic [DATA_W-1:0] read_bus_out;
  logic echo_out_true;
  logic echo_out_comp;
  logic out_valid_flag;

  modport dev (
    input k, k_n, rd_n, wr_n, dll_enable, addr_bus, write_bus_in, byte_mask_n,
    output read_bus_out, echo_out_true, echo_out_comp, out_valid_flag
  );

  modport ctrl (
    output k, k_n, rd_n, wr_n, dll_enable, addr_bus, write_bus_in, byte_mask_n,
    input read_bus_out, echo_out_true, echo_out_comp, out_valid_flag
  );
endinterface : dbs_link_if

// file: dbs_pkg.sv
package dbs_pkg;
  // Link widths; the x36 part uses only the low 19 address lines
  localparam int ADDR_W = 20;
  localparam int DATA_W = 36;
  localparam int BYTE_W = 9;
  localparam int NBYTES = 4;
  localparam int BURST = 4;
  localparam int BEATS_W = DATA_W * BURST;
  localparam int MASK_W = NBYTES * BURST;
  // Masks: bytes the 18-bit configuration leaves unused, data lines each width uses, all bytes off
  localparam logic [NBYTES-1:0] X18_BYTE_OFF = 4'hC;
  localparam logic [DATA_W-1:0] X18_DATA_MASK = 36'h0_0003_FFFF;
  localparam logic [DATA_W-1:0] X36_DATA_MASK = 36'hF_FFFF_FFFF;
  localparam logic [NBYTES-1:0] MASK_NONE = 4'hF;
  // Storage window kept small so that simulation stays light
  localparam int MEM_AW = 10;
  // Core clock and link clock derived from it
  localparam int CORE_PERIOD_NS = 20;
  localparam int K_HALF_CYC = 1;
  localparam int K_PERIOD_NS = 2 * K_HALF_CYC * CORE_PERIOD_NS;
  // Fastest link clock allowed with the DLL bypassed
  localparam int BYPASS_FMAX_MHZ = 167;
  localparam int BYPASS_MIN_PERIOD_NS = (1000 + BYPASS_FMAX_MHZ - 1) / BYPASS_FMAX_MHZ;
  // DLL lock time, counted in link clock cycles
  localparam int LOCK_CYCLES = 1024;
  // Core cycles between two commands: two full link cycles per burst
  localparam int CMD_SPACING = 4 * K_HALF_CYC;
  typedef enum logic [1:0] {
    DLL_OFF = 2'b00,
    DLL_LOCKING = 2'b01,
    DLL_LOCKED = 2'b11
  } dbs_dll_e;
endpackage : dbs_pkg

// file: dbs_sram_end.sv
`timescale 1ns/100ps
// Contract
// - Address and commands captured on true rise
// - Write data captured on both clock rises
// - Complement clock half a period from true
// - Echo clocks always toggle, even when idle
// - Echo edges line up with data changes
// - DLL off while enable low, relock after
// - Bypass gives 1.5 cycle latency, clock limited
// - Valid flag high with data, echo aligned
// - Address ignored without a command
// - 18-bit build uses low write lines only
// - 18-bit build drives low read lines only
// - Read bus driven only for accepted reads
// - Write strobe low starts a write
// - Read strobe low starts a read
// - Reads no closer than every other cycle
// - First read beat 2.5 cycles later
// - First write beat one cycle later
// - Byte masks gate each write beat
module dbs_sram_end
  import dbs_pkg::*;
#(
  parameter bit IS_X36 = 1'b1,
  parameter int LOCK_CYC = LOCK_CYCLES
) (
  dbs_link_if.dev lk,
  input wire logic rst_n,
  output logic dll_locked
);
  localparam int IW = MEM_AW + 2;
  localparam int LCW = $clog2(LOCK_CYC + 1);
  localparam logic [NBYTES-1:0] BYTE_OFF = IS_X36 ? '0 : X18_BYTE_OFF;
  localparam logic [DATA_W-1:0] DATA_MASK = IS_X36 ? X36_DATA_MASK : X18_DATA_MASK;

  logic [DATA_W-1:0] mem [0:(1 << IW)-1];

  logic dll_en_s;
  dbs_dll_e dll_st_r;
  logic [LCW-1:0] lock_cnt_r;

  logic wv0_r;
  logic wv1_r;
  logic wv2_r;
  logic [MEM_AW-1:0] wa0_r;
  logic [MEM_AW-1:0] wa1_r;
  logic [MEM_AW-1:0] wa2_r;
  logic [DATA_W-1:0] dn_r;
  logic [NBYTES-1:0] mn_r;

  logic rv1_r;
  logic rv2_r;
  logic [MEM_AW-1:0] ra1_r;
  logic [MEM_AW-1:0] ra2_r;
  logic [DATA_W-1:0] f_r [0:BURST-1];
  logic ph1_r;
  logic ph2_r;
  logic [1:0] nb_r;
  logic [DATA_W-1:0] q_p_r;
  logic [DATA_W-1:0] q_n_r;
  logic vp_r;
  logic vn_r;
  logic tp_r;
  logic tn_r;

  // Pins already run on the link clock; only the DLL enable is treated as async
  dbs_sync #(.W(1)) u_dll_sync (
    .clk(lk.k),
    .rst_n(rst_n),
    .en(1'b1),
    .d(lk.dll_enable),
    .q(dll_en_s)
  );

  wire wr_go = ~lk.wr_n;
  wire rd_go = ~lk.rd_n;
  wire locked = (dll_st_r == DLL_LOCKED);
  wire fetch_go = locked ? rv2_r : rv1_r;
  wire [MEM_AW-1:0] fetch_a = locked ? ra2_r : ra1_r;
  wire [NBYTES-1:0] din_mask_n = lk.byte_mask_n | BYTE_OFF;
  wire [NBYTES-1:0] dn_mask_n = mn_r | BYTE_OFF;

  // Port A takes the true-edge beats, port B the complement-edge beats
  wire wa_en = wv0_r | wv1_r;
  wire [IW-1:0] wa_idx = wv1_r ? {wa1_r, 2'd2} : {wa0_r, 2'd0};
  wire wb_en = wv1_r | wv2_r;
  wire [IW-1:0] wb_idx = wv1_r ? {wa1_r, 2'd1} : {wa2_r, 2'd3};

  wire echo_t = tp_r ^ tn_r;

  assign dll_locked = locked;
  assign lk.echo_out_true = echo_t;
  assign lk.echo_out_comp = ~echo_t;
  assign lk.read_bus_out = echo_t ? q_p_r : q_n_r;
  assign lk.out_valid_flag = echo_t ? vp_r : vn_r;

  always_ff @(posedge lk.k or negedge rst_n) begin
    if (!rst_n) begin
      dll_st_r <= DLL_OFF;
      lock_cnt_r <= '0;
    end else begin
      unique case (dll_st_r)
        DLL_OFF: begin
          lock_cnt_r <= '0;
          if (dll_en_s) begin
            dll_st_r <= DLL_LOCKING;
          end
        end
        DLL_LOCKING: begin
          lock_cnt_r <= lock_cnt_r + 1'b1;
          if (!dll_en_s) begin
            dll_st_r <= DLL_OFF;
          end else if (lock_cnt_r == LCW'(LOCK_CYC - 1)) begin
            dll_st_r <= DLL_LOCKED;
          end
        end
        DLL_LOCKED: begin
          if (!dll_en_s) begin
            dll_st_r <= DLL_OFF;
          end
        end
        default: begin
          dll_st_r <= DLL_OFF;
        end
      endcase
    end
  end

  // Command capture; address kept only when a command selects it
  always_ff @(posedge lk.k or negedge rst_n) begin
    if (!rst_n) begin
      wv0_r <= 1'b0;
      wv1_r <= 1'b0;
      wv2_r <= 1'b0;
      wa0_r <= '0;
      wa1_r <= '0;
      wa2_r <= '0;
      rv1_r <= 1'b0;
      rv2_r <= 1'b0;
      ra1_r <= '0;
      ra2_r <= '0;
    end else begin
      wv0_r <= wr_go;
      wv1_r <= wv0_r;
      wv2_r <= wv1_r;
      if (wr_go) begin
        wa0_r <= lk.addr_bus[MEM_AW-1:0];
      end
      wa1_r <= wa0_r;
      wa2_r <= wa1_r;
      rv1_r <= rd_go;
      rv2_r <= rv1_r;
      if (rd_go) begin
        ra1_r <= lk.addr_bus[MEM_AW-1:0];
      end
      ra2_r <= ra1_r;
    end
  end

  // Beats on the complement rise are held half a cycle for the next true rise
  always_ff @(posedge lk.k_n or negedge rst_n) begin
    if (!rst_n) begin
      dn_r <= '0;
      mn_r <= MASK_NONE;
    end else begin
      dn_r <= lk.write_bus_in & DATA_MASK;
      mn_r <= lk.byte_mask_n;
    end
  end

  // Array writes, byte by byte; unused upper bytes never written in x18
  always_ff @(posedge lk.k) begin
    for (int b = 0; b < NBYTES; b++) begin
      if (wa_en && !din_mask_n[b]) begin
        mem[wa_idx][b*BYTE_W +: BYTE_W] <= lk.write_bus_in[b*BYTE_W +: BYTE_W];
      end
      if (wb_en && !dn_mask_n[b]) begin
        mem[wb_idx][b*BYTE_W +: BYTE_W] <= dn_r[b*BYTE_W +: BYTE_W];
      end
    end
  end

  // Fetch point moves one cycle earlier while the DLL is not locked
  always_ff @(posedge lk.k or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < BURST; i++) begin
        f_r[i] <= '0;
      end
    end else if (fetch_go) begin
      for (int i = 0; i < BURST; i++) begin
        f_r[i] <= mem[{fetch_a, 2'(i)}] & DATA_MASK;
      end
    end
  end

  // True-rise beats two and four; echo true phase
  always_ff @(posedge lk.k or negedge rst_n) begin
    if (!rst_n) begin
      ph1_r <= 1'b0;
      ph2_r <= 1'b0;
      nb_r <= 2'd0;
      q_p_r <= '0;
      vp_r <= 1'b0;
      tp_r <= 1'b0;
    end else begin
      tp_r <= ~tp_r;
      ph1_r <= fetch_go;
      ph2_r <= ph1_r;
      nb_r <= fetch_go ? 2'd1 : (ph1_r ? 2'd2 : 2'd0);
      if (ph1_r) begin
        q_p_r <= f_r[1];
        vp_r <= 1'b1;
      end else if (ph2_r) begin
        q_p_r <= f_r[3];
        vp_r <= 1'b1;
      end else begin
        q_p_r <= '0;
        vp_r <= 1'b0;
      end
    end
  end

  // Complement-rise beats one and three; echo complement phase
  always_ff @(posedge lk.k_n or negedge rst_n) begin
    if (!rst_n) begin
      q_n_r <= '0;
      vn_r <= 1'b0;
      tn_r <= 1'b0;
    end else begin
      tn_r <= ~tn_r;
      unique case (nb_r)
        2'd1: begin
          q_n_r <= f_r[0];
          vn_r <= 1'b1;
        end
        2'd2: begin
          q_n_r <= f_r[2];
          vn_r <= 1'b1;
        end
        default: begin
          q_n_r <= '0;
          vn_r <= 1'b0;
        end
      endcase
    end
  end
endmodule : dbs_sram_end

// file: dbs_sync.sv
`timescale 1ns/100ps
module dbs_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else if (en) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : dbs_sync

// file: tb_ddr_burst_sram_port.sv
`timescale 1ns/100ps
module tb_ddr_burst_sram_port;
  import dbs_pkg::*;
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] seed;
    logic [MASK_W-1:0] mask;
  } dbs_row_s;
  logic core_clk = 1'b0;
  // Dropped just after time zero so every asynchronous reset sees an edge
  logic rst_n = 1'b1;
  logic ce = 1'b1;
  logic dll_on, rd_req, wr_req;
  logic [ADDR_W-1:0] cmd_addr;
  logic [BEATS_W-1:0] wr_data, rd_data, rd_data18;
  logic [MASK_W-1:0] wr_mask_n;
  logic cmd_ready, cmd_ready18, rd_valid, rd_valid18, locked, locked18;
  logic [BEATS_W-1:0] mem [0:2**MEM_AW-1];
  int n_errors = 0;
  int n_tests = 0;
  // Every read address is fully written first, since unwritten words read unknown
  dbs_row_s rows [8] = '{
    '{1'b1, 20'h00005, 36'h1_2345_6789, 16'h0000},
    '{1'b1, 20'h003A0, 36'hA_BCDE_F012, 16'h0000},
    '{1'b0, 20'h00005, 36'h0_0000_0000, 16'hFFFF},
    '{1'b1, 20'h00005, 36'hF_0F0F_0F0F, 16'h5A3C},
    '{1'b0, 20'h00005, 36'h0_0000_0000, 16'hFFFF},
    '{1'b1, 20'h003A0, 36'h0_F0F0_F0F0, 16'hFFFF},
    '{1'b0, 20'h003A0, 36'h0_0000_0000, 16'hFFFF},
    '{1'b0, 20'h00005, 36'h0_0000_0000, 16'hFFFF}};
  dbs_link_if link ();
  dbs_link_if link18 ();
  dbs_ctrl_end u_dbs_ctrl_end (.core_clk, .rst_n, .ce, .dll_on, .rd_req, .wr_req, .cmd_addr,
    .wr_data, .wr_mask_n, .cmd_ready, .rd_data, .rd_valid, .lk(link));
  dbs_sram_end #(.IS_X36(1'b1), .LOCK_CYC(4)) u_dbs_sram_end (.lk(link), .rst_n,
    .dll_locked(locked));
  dbs_ctrl_end u_dbs_ctrl_end_x18 (.core_clk, .rst_n, .ce, .dll_on, .rd_req, .wr_req,
    .cmd_addr, .wr_data, .wr_mask_n, .cmd_ready(cmd_ready18), .rd_data(rd_data18),
    .rd_valid(rd_valid18), .lk(link18));
  dbs_sram_end #(.IS_X36(1'b0), .LOCK_CYC(4)) u_dbs_sram_end_x18 (.lk(link18), .rst_n,
    .dll_locked(locked18));
  dbs_link_asserts u_chk (.core_clk, .rst_n, .k(link.k), .k_n(link.k_n), .rd_n(link.rd_n),
    .wr_n(link.wr_n), .dll_enable(link.dll_enable), .read_bus_out(link.read_bus_out),
    .echo_out_true(link.echo_out_true), .echo_out_comp(link.echo_out_comp),
    .out_valid_flag(link.out_valid_flag));
  initial begin
    forever #(CORE_PERIOD_NS / 2) core_clk = ~core_clk;
  end
  task automatic cmp_data(input logic [BEATS_W-1:0] got, input logic [BEATS_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_data
  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val
  function automatic logic [BEATS_W-1:0] merge(input logic [BEATS_W-1:0] old,
    input logic [BEATS_W-1:0] d, input logic [MASK_W-1:0] m);
    logic [BEATS_W-1:0] r;
    r = old;
    for (int j = 0; j < MASK_W; j++) if (!m[j]) r[j*BYTE_W +: BYTE_W] = d[j*BYTE_W +: BYTE_W];
    return r;
  endfunction : merge
  task automatic issue(input logic wr, input logic [ADDR_W-1:0] a,
    input logic [BEATS_W-1:0] d, input logic [MASK_W-1:0] m);
    int i;
    wr_req = wr;
    rd_req = !wr;
    cmd_addr = a;
    wr_data = d;
    wr_mask_n = m;
    for (i = 0; i < 20 && cmd_ready !== 1'b1; i++) @(negedge core_clk);
    @(posedge core_clk);
    if (wr) mem[a[MEM_AW-1:0]] = merge(mem[a[MEM_AW-1:0]], d, m);
  endtask : issue
  task automatic collect(input logic [BEATS_W-1:0] exp, input int lat);
    int n;
    for (n = 1; n < 40; n++) begin
      @(negedge core_clk);
      rd_req = 1'b0;
      wr_req = 1'b0;
      if (rd_valid === 1'b1) break;
    end
    cmp_val(n[7:0], lat[7:0] + 8'h01);
    cmp_data(rd_data, exp);
    cmp_data(rd_data18, exp & {BURST{X18_DATA_MASK}});
    cmp_val({7'h00, rd_valid18}, 8'h01);
  endtask : collect
  task automatic run_op(input dbs_row_s r, input int lat);
    logic [DATA_W-1:0] s;
    s = r.seed;
    issue(r.wr, r.addr, {s ^ 36'h3, s ^ 36'h2, s ^ 36'h1, s}, r.mask);
    if (r.wr) begin
      @(negedge core_clk);
      wr_req = 1'b0;
      // Coherency with in-flight writes is not modelled, so let the burst land
      repeat (8) @(negedge core_clk);
    end else begin
      collect(mem[r.addr[MEM_AW-1:0]], lat);
    end
  endtask : run_op
  task results;
    $display("Checks %0d, errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  initial begin
    #(20000 * CORE_PERIOD_NS);
    n_errors++;
    results();
  end
  initial begin
    {dll_on, rd_req, wr_req} = 3'h0;
    cmd_addr = '0;
    wr_data = '0;
    wr_mask_n = '1;
    #1 rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    cmp_val({4'h0, cmd_ready, cmd_ready18, rd_valid, rd_valid18}, 8'h00);
    cmp_val({link.k, link.rd_n, link.wr_n, link.out_valid_flag, link.byte_mask_n}, 8'h6F);
    cmp_data({{(BEATS_W - DATA_W){1'b0}}, link.read_bus_out}, '0);
    rst_n = 1'b1;
    foreach (rows[i]) run_op(rows[i], 10);
    dll_on = 1'b1;
    repeat (80) @(negedge core_clk);
    cmp_val({6'h00, locked, locked18}, 8'h03);
    run_op(rows[2], 12);
    // Two reads held back to back: the second is taken one slot after the first
    issue(1'b0, rows[2].addr, '0, MASK_NONE);
    @(negedge core_clk);
    issue(1'b0, rows[6].addr, '0, MASK_NONE);
    collect(mem[rows[2].addr[MEM_AW-1:0]], 8);
    collect(mem[rows[6].addr[MEM_AW-1:0]], 3);
    dll_on = 1'b0;
    repeat (20) @(negedge core_clk);
    cmp_val({6'h00, locked, locked18}, 8'h00);
    run_op(rows[6], 10);
    results();
  end
endmodule : tb_ddr_burst_sram_port
